// >>> design/logic_string_branch_decode.v
// decoder for logic, string and branch forms with cycle-cost pacing
`timescale 1ns/1ps
`include "decode_defs.vh"
module logic_string_branch_decode (
    input wire core_clk,
    input wire rst_n,
    input wire narrow_bus,
    input wire [7:0] byte_in,
    input wire byte_valid,
    output wire byte_ready,
    input wire [15:0] count_register,
    output reg [3:0] instr_class,
    output reg [7:0] opcode_q,
    output reg [2:0] op_field,
    output reg word_width,
    output reg dir_to_reg,
    output reg mem_operand,
    output reg repeat_active,
    output reg repeat_until_zero,
    output reg [15:0] iter_count,
    output reg [9:0] cycle_cost,
    output reg illegal,
    output reg decode_valid,
    output wire exec_busy,
    output wire exec_done
);
    localparam ST_OP = 2'h0;
    localparam ST_MODRM = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg loop_q;
    reg loop_z_q;
    reg [7:0] op_q;
    reg [9:0] cost_d;
    reg [3:0] cls_d;
    reg ill_d;
    reg need_modrm;
    reg is_string;
    reg [9:0] ov;
    reg [9:0] it;
    reg [9:0] base;
    reg [25:0] loop_total;
    reg [7:0] cur_op;
    reg [7:0] mrm;
    wire mem;
    wire wbit;
    wire load_exec;
    wire [9:0] word_extra;

    assign byte_ready = (state_q != ST_RUN);
    assign wbit = cur_op[0];
    assign mem = (mrm[7:6] != `MOD_REG);
    // narrow bus adds per-transfer penalty only on word memory traffic
    assign word_extra = (narrow_bus && wbit) ? `CYC_WORD_ADD : 10'h000;
    assign load_exec = byte_valid && byte_ready && (state_d == ST_RUN);

    always @* begin
        cur_op = (state_q == ST_MODRM) ? op_q : byte_in;
        mrm = (state_q == ST_MODRM) ? byte_in : 8'h00;
        need_modrm = (byte_in[7:2] == `OP_XOR_RM) || (byte_in[7:1] == `OP_GRP1) ||
            (byte_in[7:1] == `OP_GRP3) || (byte_in == `OP_GRP5);
        is_string = 1'b0;
        ov = 10'h000;
        it = 10'h000;
        cls_d = `CLS_NONE;
        cost_d = 10'h000;
        ill_d = 1'b0;
        // a nonzero loop overhead marks the string forms
        case (cur_op[7:1])
            `OP_SMOVE: ov = `LOOP_OV_SMOVE;
            `OP_SCMP: ov = `LOOP_OV_SCMP;
            `OP_SSCAN: ov = `LOOP_OV_SSCAN;
            `OP_SLOAD: ov = `LOOP_OV_SLOAD;
            `OP_SSTORE: ov = `LOOP_OV_SSTORE;
            `OP_PIN: ov = `LOOP_OV_IO;
            `OP_POUT: ov = `LOOP_OV_IO;
            default: ov = 10'h000;
        endcase
        is_string = (ov != 10'h000);
        case (cur_op[7:1])
            `OP_SMOVE: it = `LOOP_IT_SMOVE;
            `OP_SCMP: it = `LOOP_IT_SCMP;
            `OP_SSCAN: it = `LOOP_IT_SSCAN;
            `OP_SLOAD: it = `LOOP_IT_SLOAD;
            `OP_SSTORE: it = `LOOP_IT_SSTORE;
            `OP_PIN: it = `LOOP_IT_IO;
            `OP_POUT: it = `LOOP_IT_IO;
            default: it = 10'h000;
        endcase
        case (cur_op[7:1])
            `OP_SMOVE: base = `CYC_SMOVE;
            `OP_SCMP: base = `CYC_SCMP;
            `OP_SSCAN: base = `CYC_SSCAN;
            `OP_SLOAD: base = `CYC_SLOAD;
            `OP_SSTORE: base = `CYC_SSTORE;
            `OP_PIN: base = `CYC_PIN;
            `OP_POUT: base = `CYC_POUT;
            default: base = 10'h000;
        endcase
        // single in/out strings stay at 14 on both variants, repeated ones take 8 per iteration, no narrow penalty
        if (cur_op[7:1] == `OP_PIN || cur_op[7:1] == `OP_POUT) begin
            it = loop_q ? it : base;
        end else begin
            it = loop_q ? it + word_extra : base + word_extra;
        end
        if (state_q == ST_OP) begin
            if (is_string) begin
                cls_d = `CLS_STRING;
                // overhead plus per-iteration, saturating to the counter width
                loop_total = {16'h0000, ov} + count_register * it;
                cost_d = loop_q ? ((loop_total > 26'h00003ff) ? 10'h3ff : loop_total[9:0])
                               : it;
            end else if (cur_op[7:1] == `OP_XOR_ACC) begin
                cls_d = `CLS_XOR;
                cost_d = wbit ? `CYC_XORA_W : `CYC_XORA;
            end else if (cur_op == `OP_BR_SHORT || cur_op == `OP_BR_NEAR ||
                         cur_op == `OP_BR_FAR) begin
                cls_d = `CLS_BRANCH;
                cost_d = `CYC_BR;
            end else if (cur_op == `OP_CALL_NEAR) begin
                cls_d = `CLS_CALL;
                cost_d = narrow_bus ? `CYC_CALL_NW : `CYC_CALL_N;
            end else if (cur_op == `OP_CALL_FAR) begin
                cls_d = `CLS_CALL;
                cost_d = narrow_bus ? `CYC_CALL_FN : `CYC_CALL_F;
            end else begin
                ill_d = !need_modrm;
            end
            loop_total = 26'h0000000;
        end else begin
            loop_total = 26'h0000000;
            if (cur_op[7:2] == `OP_XOR_RM) begin
                cls_d = `CLS_XOR;
                cost_d = mem ? `CYC_XOR_M + word_extra : `CYC_XOR_R;
            end else if (cur_op[7:1] == `OP_GRP1 && mrm[5:3] == `FLD_XOR) begin
                cls_d = `CLS_XOR;
                cost_d = mem ? `CYC_XORI_M + word_extra : `CYC_XORI_R;
            end else if (cur_op[7:1] == `OP_GRP3 && mrm[5:3] == `FLD_NOT) begin
                cls_d = `CLS_NOT;
                cost_d = mem ? `CYC_NOT_M + word_extra : `CYC_NOT_R;
            end else if (cur_op == `OP_GRP5) begin
                case (mrm[5:3])
                    `FLD_CALL_IND: begin
                        cls_d = `CLS_CALL;
                        cost_d = narrow_bus ? (mem ? `CYC_CALLI_MN : `CYC_CALLI_RN)
                                            : (mem ? `CYC_CALLI_M : `CYC_CALLI_R);
                    end
                    `FLD_BR_IND: begin
                        cls_d = `CLS_BRANCH;
                        cost_d = mem ? (narrow_bus ? `CYC_BRI_MN : `CYC_BRI_M)
                                     : `CYC_BRI_R;
                    end
                    `FLD_CALLF_IND: begin
                        cls_d = `CLS_CALL;
                        ill_d = !mem;
                        cost_d = narrow_bus ? `CYC_CALLF_IN : `CYC_CALLF_I;
                    end
                    `FLD_BRF_IND: begin
                        cls_d = `CLS_BRANCH;
                        ill_d = !mem;
                        cost_d = narrow_bus ? `CYC_BRF_IN : `CYC_BRF_I;
                    end
                    default: ill_d = 1'b1;
                endcase
            end else begin
                ill_d = 1'b1;
            end
        end
        if (ill_d) begin
            cost_d = 10'h000;
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OP: begin
                if (byte_valid && !(byte_in[7:1] == `OP_LOOP_PFX)) begin
                    state_d = need_modrm ? ST_MODRM : (ill_d ? ST_OP : ST_RUN);
                end
            end
            ST_MODRM: begin
                if (byte_valid) begin
                    state_d = ill_d ? ST_OP : ST_RUN;
                end
            end
            ST_RUN: begin
                if (exec_done) begin
                    state_d = ST_OP;
                end
            end
            default: state_d = ST_OP;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OP;
            loop_q <= 1'b0;
            loop_z_q <= 1'b0;
            op_q <= 8'h00;
            instr_class <= 4'h0;
            opcode_q <= 8'h00;
            op_field <= 3'h0;
            word_width <= 1'b0;
            dir_to_reg <= 1'b0;
            mem_operand <= 1'b0;
            repeat_active <= 1'b0;
            repeat_until_zero <= 1'b0;
            iter_count <= 16'h0000;
            cycle_cost <= 10'h000;
            illegal <= 1'b0;
            decode_valid <= 1'b0;
        end else begin
            state_q <= state_d;
            decode_valid <= 1'b0;
            if (byte_valid && byte_ready) begin
                if (state_q == ST_OP && byte_in[7:1] == `OP_LOOP_PFX) begin
                    loop_q <= 1'b1;
                    loop_z_q <= byte_in[0];
                end else if (state_q == ST_OP && need_modrm) begin
                    op_q <= byte_in;
                end else begin
                    decode_valid <= 1'b1;
                    illegal <= ill_d;
                    instr_class <= cls_d;
                    opcode_q <= cur_op;
                    op_field <= mrm[5:3];
                    word_width <= wbit;
                    dir_to_reg <= cur_op[1] && (cur_op[7:2] == `OP_XOR_RM);
                    mem_operand <= mem && (state_q == ST_MODRM);
                    // prefix only activates a repeat in front of a string opcode; repeat_until_zero takes its bit regardless
                    repeat_active <= loop_q && is_string;
                    repeat_until_zero <= loop_z_q;
                    iter_count <= (loop_q && is_string) ? count_register : 16'h0001;
                    cycle_cost <= cost_d;
                    loop_q <= 1'b0;
                    loop_z_q <= 1'b0;
                end
            end
        end
    end

    cycle_counter pacer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(load_exec),
        .cycles(cost_d),
        .busy(exec_busy),
        .done(exec_done)
    );
endmodule

// >>> design/decode_defs.vh
// opcode patterns, field codes and cycle costs for the string/branch/logic decoder
`ifndef DECODE_DEFS_VH
`define DECODE_DEFS_VH
`define OP_XOR_RM      6'h0c
`define OP_XOR_ACC     7'h1a
`define OP_GRP1        7'h40
`define OP_GRP3        7'h7b
`define OP_SMOVE 7'h52
`define OP_SCMP 7'h53
`define OP_SSCAN 7'h57
`define OP_SLOAD 7'h56
`define OP_SSTORE 7'h55
`define OP_PIN 7'h36
`define OP_POUT 7'h37
`define OP_LOOP_PFX 7'h79
`define OP_LOOP_PLAIN 8'hf2
`define OP_GRP5        8'hff
`define OP_CALL_NEAR   8'he8
`define OP_CALL_FAR    8'h9a
`define OP_BR_SHORT 8'heb
`define OP_BR_NEAR 8'he9
`define OP_BR_FAR 8'hea
`define FLD_XOR        3'h6
`define FLD_NOT        3'h2
`define FLD_CALL_IND   3'h2
`define FLD_CALLF_IND  3'h3
`define FLD_BR_IND 3'h4
`define FLD_BRF_IND 3'h5
`define MOD_REG        2'h3
`define CYC_XOR_R      10'h003
`define CYC_XOR_M      10'h00a
`define CYC_XORI_R     10'h004
`define CYC_XORI_M     10'h010
`define CYC_XORA       10'h003
`define CYC_XORA_W     10'h004
`define CYC_NOT_R      10'h003
`define CYC_NOT_M      10'h00a
`define CYC_SMOVE 10'h00e
`define CYC_SCMP 10'h016
`define CYC_SSCAN 10'h00f
`define CYC_SLOAD 10'h00c
`define CYC_SSTORE 10'h00a
`define CYC_PIN 10'h00e
`define CYC_POUT 10'h00e
`define CYC_WORD_ADD   10'h004
`define LOOP_OV_SMOVE 10'h008
`define LOOP_IT_SMOVE 10'h008
`define LOOP_OV_SCMP 10'h005
`define LOOP_IT_SCMP 10'h016
`define LOOP_OV_SSCAN 10'h005
`define LOOP_IT_SSCAN 10'h00f
`define LOOP_OV_SLOAD 10'h006
`define LOOP_IT_SLOAD 10'h00b
`define LOOP_OV_SSTORE 10'h006
`define LOOP_IT_SSTORE 10'h009
`define LOOP_OV_IO 10'h008
`define LOOP_IT_IO 10'h008
`define CYC_CALL_N     10'h00f
`define CYC_CALL_NW    10'h013
`define CYC_CALLI_R    10'h00d
`define CYC_CALLI_M    10'h013
`define CYC_CALLI_RN   10'h011
`define CYC_CALLI_MN   10'h01b
`define CYC_CALL_F     10'h017
`define CYC_CALL_FN    10'h01f
`define CYC_CALLF_I    10'h026
`define CYC_CALLF_IN   10'h036
`define CYC_BR 10'h00e
`define CYC_BRI_R 10'h00b
`define CYC_BRI_M 10'h011
`define CYC_BRI_MN 10'h015
`define CYC_BRF_I 10'h01a
`define CYC_BRF_IN 10'h022
`define CLS_NONE       4'h0
`define CLS_XOR        4'h1
`define CLS_NOT        4'h2
`define CLS_STRING     4'h3
`define CLS_CALL       4'h4
`define CLS_BRANCH     4'h5
`endif

// >>> design/cycle_counter.v
// down-counter that paces one instruction to its cycle cost
`timescale 1ns/1ps
module cycle_counter (
    input wire core_clk,
    input wire rst_n,
    input wire load,
    input wire [9:0] cycles,
    output wire busy,
    output reg done
);
    reg [9:0] cnt_q;
    assign busy = (cnt_q != 10'h000);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 10'h000;
            done <= 1'b0;
        end else begin
            done <= (cnt_q == 10'h001);
            if (load && !busy) begin
                cnt_q <= cycles;
            end else if (busy) begin
                cnt_q <= cnt_q - 10'h001;
            end
        end
    end
endmodule

// >>> tb/decode_asserts.sv
// checker for decoder pacing and decode outputs
`timescale 1ns/1ps
module decode_asserts (
    input wire core_clk,
    input wire rst_n,
    input wire byte_ready,
    input wire [3:0] instr_class,
    input wire [7:0] opcode_q,
    input wire [2:0] op_field,
    input wire mem_operand,
    input wire repeat_active,
    input wire [15:0] iter_count,
    input wire [9:0] cycle_cost,
    input wire illegal,
    input wire decode_valid,
    input wire exec_busy,
    input wire exec_done
);
    default clocking dclk @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    property p_dv_pulse;
        decode_valid |=> !decode_valid;
    endproperty
    a_dv_pulse: assert property (p_dv_pulse) else $error("decode pulse too long");
    property p_run_start;
        decode_valid && !illegal |-> exec_busy && !byte_ready;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run did not start");
    property p_far_reject;
        decode_valid && opcode_q == 8'hff && !mem_operand && op_field[0] && op_field[2:1] != 2'h0
            |-> illegal && cycle_cost == 10'h000 ##1 !exec_busy [*3];
    endproperty
    a_far_reject: assert property (p_far_reject) else $error("far form with register kept");
    property p_busy_done;
        $fell(exec_busy) |-> exec_done;
    endproperty
    a_busy_done: assert property (p_busy_done) else $error("done not after busy");
    property p_done_ready;
        exec_done |-> !exec_busy ##1 byte_ready;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("not ready at done");
    property p_single_iter;
        decode_valid && instr_class == 4'h3 && !repeat_active |-> iter_count == 16'h0001;
    endproperty
    a_single_iter: assert property (p_single_iter) else $error("single op count wrong");
    property p_loop_cmp;
        decode_valid && repeat_active && opcode_q == 8'ha6 && iter_count < 16'h002f
            |-> cycle_cost == 10'h005 + 10'h016 * iter_count[9:0];
    endproperty
    a_loop_cmp: assert property (p_loop_cmp) else $error("repeated compare cost wrong");
    property p_loop_out;
        decode_valid && repeat_active && opcode_q == 8'h6e && iter_count < 16'h007f
            |-> cycle_cost == 10'h008 + 10'h008 * iter_count[9:0];
    endproperty
    a_loop_out: assert property (p_loop_out) else $error("repeated output cost wrong");
endmodule
bind logic_string_branch_decode decode_asserts u_chk (.core_clk, .rst_n, .byte_ready,
    .instr_class, .opcode_q, .op_field, .mem_operand, .repeat_active, .iter_count,
    .cycle_cost, .illegal, .decode_valid, .exec_busy, .exec_done);

// >>> tb/logic_string_branch_decode_tb.sv
// self-checking bench for the logic, string and branch decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module logic_string_branch_decode_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic narrow_bus = 1'b0;
    logic byte_valid = 1'b0;
    logic [7:0] byte_in = 8'h00;
    logic [15:0] count_register = 16'h0000;
    logic byte_ready, word_width, dir_to_reg, mem_operand, repeat_active, repeat_until_zero;
    logic illegal, decode_valid, exec_busy, exec_done;
    logic [3:0] instr_class;
    logic [7:0] opcode_q, r, m;
    logic [2:0] op_field;
    logic [15:0] iter_count;
    logic [9:0] cycle_cost;
    logic [31:0] seed = 32'ha7a2f504;
    logic [6:0] str_ops [7] = '{7'h52, 7'h53, 7'h57, 7'h56, 7'h55, 7'h36, 7'h37};
    int err_count = 0;
    int num_checks = 0;
    int i;
    always #10 core_clk = ~core_clk;
    logic_string_branch_decode dut (.core_clk, .rst_n, .narrow_bus, .byte_in, .byte_valid,
        .byte_ready, .count_register, .instr_class, .opcode_q, .op_field, .word_width,
        .dir_to_reg, .mem_operand, .repeat_active, .repeat_until_zero, .iter_count,
        .cycle_cost, .illegal, .decode_valid, .exec_busy, .exec_done);
    function [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // narrow word penalty once per xor/not memory form, once per string iteration, never on port i/o or group-5 forms
    function [9:0] exp_cost(input [7:0] op, input [7:0] mb, input rpt, input nb, input [15:0] n);
        int b, ov, it, pen, mem, v;
        mem = mb[7:6] != 2'h3;
        pen = (nb && op[0]) ? 4 : 0;
        it = 0;
        ov = 0;
        case (op[7:1])
            7'h52: begin b = 14 + pen; ov = 8; it = 8; end
            7'h53: begin b = 22 + pen; ov = 5; it = 22; end
            7'h57: begin b = 15 + pen; ov = 5; it = 15; end
            7'h56: begin b = 12 + pen; ov = 6; it = 11; end
            7'h55: begin b = 10 + pen; ov = 6; it = 9; end
            7'h36, 7'h37: begin pen = 0; b = 14; ov = 8; it = 8; end
            7'h18, 7'h19, 7'h7b: b = mem ? 10 + pen : 3;
            7'h40: b = mem ? 16 + pen : 4;
            7'h1a: b = op[0] ? 4 : 3;
            7'h7f: b = mb[5:3] == 3'h2 ? (nb ? (mem ? 27 : 17) : (mem ? 19 : 13)) :
                mb[5:3] == 3'h4 ? (mem ? (nb ? 21 : 17) : 11) :
                mb[5:3] == 3'h3 ? (nb ? 54 : 38) : (nb ? 34 : 26);
            default: b = (op == 8'he8) ? (nb ? 19 : 15) : (op == 8'h9a) ? (nb ? 31 : 23) : 14;
        endcase
        v = (rpt && it != 0) ? ov + (it + pen) * n : b;
        return (v > 1023) ? 10'h3ff : v[9:0];
    endfunction
    function [3:0] exp_cls(input [7:0] op, input [7:0] mb);
        case (op[7:1])
            7'h52, 7'h53, 7'h57, 7'h56, 7'h55, 7'h36, 7'h37: return 4'h3;
            7'h18, 7'h19, 7'h1a, 7'h40: return 4'h1;
            7'h7b: return 4'h2;
            7'h7f: return (mb[5:3] == 3'h2 || mb[5:3] == 3'h3) ? 4'h4 : 4'h5;
            default: return (op == 8'he8 || op == 8'h9a) ? 4'h4 : 4'h5;
        endcase
    endfunction
    task send(input [7:0] b);
        int n;
        begin
            byte_in = b;
            byte_valid = 1'b1;
            n = 0;
            while (byte_ready !== 1'b1 && n < 2000) begin
                @(negedge core_clk);
                n++;
            end
            @(negedge core_clk);
        end
    endtask
    task run(input [7:0] pre, input [7:0] op, input [7:0] mb, input has_m);
        logic rpt, ill;
        logic [9:0] e;
        int k;
        begin
            rpt = pre[7:1] == 7'h79 && (op[7:2] == 6'h29 || op[7:2] == 6'h2b ||
                op[7:1] == 7'h55 || op[7:2] == 6'h1b);
            ill = op == 8'hff && mb[7:6] == 2'h3 && (mb[5:3] == 3'h3 || mb[5:3] == 3'h5);
            e = ill ? 10'h000 : exp_cost(op, mb, rpt, narrow_bus, count_register);
            if (pre != 8'h00) send(pre);
            send(op);
            if (has_m) send(mb);
            byte_valid = 1'b0;
            k = 0;
            while (decode_valid !== 1'b1 && k < 8) begin
                @(negedge core_clk);
                k++;
            end
            `CHK("decode_valid", 1'b1, decode_valid)
            `CHK("cycle_cost", e, cycle_cost)
            `CHK("illegal", ill, illegal)
            `CHK("opcode_q", op, opcode_q)
            `CHK("instr_class", exp_cls(op, mb), instr_class)
            `CHK("repeat_active", rpt, repeat_active)
            if (rpt) `CHK("until_zero", pre[0], repeat_until_zero)
            if (rpt) `CHK("iter_count", count_register, iter_count)
            if (has_m) `CHK("op_field", mb[5:3], op_field)
            if (has_m) `CHK("mem_operand", mb[7:6] != 2'h3, mem_operand)
            if (op[7:2] == 6'h0c) `CHK("dir_to_reg", op[1], dir_to_reg)
            if (op[7:4] != 4'he) `CHK("word_width", op[0], word_width)
            k = 0;
            if (ill) begin
                repeat (4) @(negedge core_clk);
                `CHK("busy after reject", 1'b0, exec_busy)
            end else begin
                while (exec_done !== 1'b1 && k < 1100) begin
                    @(negedge core_clk);
                    k++;
                end
                `CHK("run length", e, k[9:0])
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        for (i = 0; i < 28; i++) begin
            narrow_bus = i[0];
            run(8'h00, {str_ops[i / 4], i[1]}, 8'h00, 1'b0);
        end
        // counts of zero, at the saturation edge and far beyond it, then random small counts
        for (i = 0; i < 21; i++) begin
            r = rnd();
            count_register = (i == 0) ? 16'h0000 : (i == 1) ? 16'h002f :
                (i == 2) ? 16'h1000 : {12'h000, r[3:0]};
            narrow_bus = r[4];
            run({7'h79, r[5]}, {str_ops[i % 7], i[3] ^ i[0]}, 8'h00, 1'b0);
        end
        // the last case carries a prefix that a branch must drop
        for (i = 0; i < 4; i++) run(i == 3 ? 8'hf3 : 8'h00, i == 3 ? 8'heb : 8'he9 + i, 8'h00, 1'b0);
        // direct calls and the accumulator xor on both variants
        for (i = 0; i < 8; i++) begin
            narrow_bus = i[0];
            run(8'h00, (i < 2) ? 8'he8 : (i < 4) ? 8'h9a : {7'h1a, i[0]}, 8'h00, 1'b0);
        end
        for (i = 0; i < 16; i++) begin
            r = rnd();
            narrow_bus = i[3];
            m = {(i < 4) ? 2'h3 : r[7:6], 3'h2 + i[1:0], r[2:0]};
            run(8'h00, 8'hff, m, 1'b1);
        end
        for (i = 0; i < 24; i++) begin
            r = rnd();
            m = rnd();
            if (i < 6) m[7:6] = 2'h3;
            if (i % 3 != 0) m[5:3] = (i % 3 == 1) ? 3'h2 : 3'h6;
            narrow_bus = r[7];
            run(8'h00, (i % 3 == 0) ? {6'h0c, r[1:0]} : (i % 3 == 1) ? {7'h7b, r[0]} :
                {7'h40, r[0]}, m, 1'b1);
        end
        // reset in mid-run must free the byte port at once
        count_register = 16'h0009;
        send(8'hf2);
        send(8'ha4);
        byte_valid = 1'b0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        `CHK("busy in reset", 1'b0, exec_busy)
        `CHK("ready in reset", 1'b1, byte_ready)
        rst_n = 1'b1;
        run(8'h00, 8'hae, 8'h00, 1'b0);
        finish_test;
    end
endmodule
